/* File: hpsc_pkg.sv */
// Package of offsets, field layouts and carriers for the hot-plug slot configuration registers.
package hpsc_pkg;
    // Byte offsets within the working register set.
    localparam logic [7:0] HPSC_OFF_BASE = 8'h00;
    localparam logic [7:0] HPSC_OFF_SLOTCFG = 8'h0c;
    localparam logic [7:0] HPSC_OFF_BUSMODE = 8'h10;
    localparam logic [7:0] HPSC_OFF_IRQNUM = 8'h12;
    // Reset values.
    localparam logic [31:0] HPSC_RST_BASE = 32'h0000_0000;
    localparam logic [31:0] HPSC_RST_SLOTCFG = 32'h0000_0000;
    localparam logic [15:0] HPSC_RST_BUSMODE = 16'h0000;
    localparam logic [7:0] HPSC_RST_IRQNUM = 8'h00;
    // Slot configuration field positions.
    localparam int HPSC_ABP_BIT = 31;
    localparam int HPSC_LSP_BIT = 30;
    localparam int HPSC_DIR_BIT = 29;
    localparam int HPSC_PSL_LSB = 16;
    localparam int HPSC_PSL_MSB = 26;
    localparam int HPSC_FDN_LSB = 8;
    localparam int HPSC_FDN_MSB = 12;
    localparam int HPSC_CNT_LSB = 0;
    localparam int HPSC_CNT_MSB = 4;
    // Writable bits of the slot configuration word; the rest are reserved.
    localparam logic [31:0] HPSC_SLOTCFG_MASK = 32'he7ff_1f1f;
    // Bus mode codes.
    localparam logic [2:0] HPSC_MODE_CONV33 = 3'h0;
    localparam logic [2:0] HPSC_MODE_CONV66 = 3'h1;
    localparam logic [2:0] HPSC_MODE_PCIX66 = 3'h2;
    localparam logic [2:0] HPSC_MODE_PCIX100 = 3'h3;
    localparam logic [2:0] HPSC_MODE_PCIX133 = 3'h4;

    // Register access request.
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } hpsc_req_t;

    // Register access answer.
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } hpsc_rsp_t;

    // Decoded slot configuration as seen by the rest of the controller.
    typedef struct packed {
        logic attention_button_present;
        logic latch_sensor_present;
        logic slot_label_direction;
        logic [10:0] physical_slot_label;
        logic [4:0] first_slot_device_number;
        logic [4:0] slot_count;
    } hpsc_cfg_t;
endpackage : hpsc_pkg

/* File: hpsc_wonce.sv */
// Write-once register with byte enables and a mask of implemented bits.
`timescale 1ns/1ps
`default_nettype none
module hpsc_wonce
    import hpsc_pkg::*;
#(
    parameter logic [31:0] MASK = HPSC_SLOTCFG_MASK,
    parameter logic [31:0] RST = HPSC_RST_SLOTCFG
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Write strobe
    input wire logic wr_i,
    input wire logic [3:0] be_i,
    input wire logic [31:0] wdata_i,
    // Stored value
    output logic [31:0] value_o,
    output logic locked_o
);
    typedef struct packed {
        logic [31:0] val;
        logic locked;
    } hpsc_wonce_st_t;

    hpsc_wonce_st_t s_q, s_d;

    // The first write after reset is kept; all later writes are dropped.
    // write once lock
    always_comb begin
        s_d = s_q;
        if (wr_i && !s_q.locked) begin
            for (int i = 0; i < 4; i++) begin
                if (be_i[i]) begin
                    s_d.val[i*8 +: 8] = wdata_i[i*8 +: 8] & MASK[i*8 +: 8];
                end
            end
            s_d.locked = 1'b1;
        end
    end

    // State register.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q <= '{val: RST, locked: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign value_o = s_q.val;
    assign locked_o = s_q.locked;

    locked_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_q.locked |=> s_q.val == $past(s_q.val)) else $error("write-once value changed");
endmodule : hpsc_wonce
`default_nettype wire

/* File: hpsc_sync.sv */
// Two-flop synchroniser for a bus of slow levels.
`timescale 1ns/1ps
`default_nettype none
module hpsc_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] ff1;
        logic [W-1:0] ff2;
    } hpsc_sync_st_t;

    hpsc_sync_st_t s_q, s_d;

    // The first stage is read only by the second.
    always_comb begin
        s_d.ff1 = d_i;
        s_d.ff2 = s_q.ff1;
    end

    // State register.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q_o = s_q.ff2;
endmodule : hpsc_sync
`default_nettype wire

/* File: hpsc_regs.sv */
// Hot-plug slot configuration register bank: base offset, slot config, bus mode, message number.
// Function
// - Base offset register always reads zero; working set starts at base.
// - Write-once bit 31 reports an attention button on every slot.
// - Write-once bit 30 reports a latch sensor on every slot.
// - Bit 29 picks slot label direction: set counts up, clear down.
// - Bits 26:16 hold the physical slot label of the first slot.
// - Bits 12:8 hold the device number of the first hot-plug slot.
// - Bits 4:0 hold the slot count, which must never read zero; here a zero count is stored and reads back zero.
// - With no slots governed, the capability entry is withdrawn.
// - Bus mode bits 2:0 report the current secondary bus speed and mode.
// - Message number mirrors the MSI multiple message enable field.
`timescale 1ns/1ps
`default_nettype none
module hpsc_regs
    import hpsc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Register access, same clock
    input wire hpsc_req_t req_i,
    output hpsc_rsp_t rsp_o,
    // Bus state from the secondary bus logic, other domain
    input wire logic [2:0] bus_mode_i,
    // MSI multiple message enable from the MSI capability, same clock
    input wire logic [2:0] multi_message_enable_i,
    // Decoded configuration
    output hpsc_cfg_t cfg_o,
    output logic cap_present_o,
    output logic [10:0] last_slot_label_o
);
    typedef struct packed {
        hpsc_rsp_t rsp;
        hpsc_cfg_t cfg;
        logic cap_present;
        logic [10:0] last_label;
    } hpsc_regs_st_t;

    hpsc_regs_st_t s_q, s_d;
    logic [31:0] slotcfg;
    logic cfg_locked;
    logic [2:0] mode_sync;
    logic slot_wr;

    // Last slot label reached by stepping from the first label.
    function automatic logic [10:0] label_end(input logic [10:0] first, input logic up,
                                              input logic [4:0] cnt);
        logic [10:0] step;
        step = (cnt == 5'h00) ? 11'h000 : {6'h00, cnt - 5'h01};
        label_end = up ? 11'(first + step) : 11'(first - step);
    endfunction : label_end

    assign slot_wr = req_i.wr && (req_i.addr == HPSC_OFF_SLOTCFG);

    hpsc_wonce #(
        .MASK(HPSC_SLOTCFG_MASK),
        .RST(HPSC_RST_SLOTCFG)
    ) u_slotcfg (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .wr_i(slot_wr),
        .be_i(req_i.be),
        .wdata_i(req_i.wdata),
        .value_o(slotcfg),
        .locked_o(cfg_locked)
    );

    // The bus mode comes from the secondary bus clock, so it is synchronised first.
    hpsc_sync #(
        .W(3)
    ) u_mode_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .d_i(bus_mode_i),
        .q_o(mode_sync)
    );

    // Read decode and derived configuration.
    always_comb begin
        s_d = s_q;
        s_d.rsp.ack = req_i.rd || req_i.wr;
        s_d.rsp.rdata = 32'h0000_0000;
        if (req_i.rd) begin
            case (req_i.addr)
                HPSC_OFF_BASE: s_d.rsp.rdata = HPSC_RST_BASE;
                HPSC_OFF_SLOTCFG: s_d.rsp.rdata = slotcfg & HPSC_SLOTCFG_MASK;
                HPSC_OFF_BUSMODE: s_d.rsp.rdata = {16'h0000, 13'h0000, mode_sync};
                HPSC_OFF_IRQNUM: s_d.rsp.rdata = {27'h000_0000, 5'(multi_message_enable_i)};
                default: s_d.rsp.rdata = 32'h0000_0000;
            endcase
        end
        s_d.cfg.attention_button_present = slotcfg[HPSC_ABP_BIT];
        s_d.cfg.latch_sensor_present = slotcfg[HPSC_LSP_BIT];
        s_d.cfg.slot_label_direction = slotcfg[HPSC_DIR_BIT];
        s_d.cfg.physical_slot_label = slotcfg[HPSC_PSL_MSB:HPSC_PSL_LSB];
        s_d.cfg.first_slot_device_number = slotcfg[HPSC_FDN_MSB:HPSC_FDN_LSB];
        s_d.cfg.slot_count = slotcfg[HPSC_CNT_MSB:HPSC_CNT_LSB];
        s_d.cap_present = (slotcfg[HPSC_CNT_MSB:HPSC_CNT_LSB] != 5'h00);
        s_d.last_label = label_end(slotcfg[HPSC_PSL_MSB:HPSC_PSL_LSB],
                                   slotcfg[HPSC_DIR_BIT],
                                   slotcfg[HPSC_CNT_MSB:HPSC_CNT_LSB]);
    end

    // State register; outputs come straight from it.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rsp_o = s_q.rsp;
    assign cfg_o = s_q.cfg;
    assign cap_present_o = s_q.cap_present;
    assign last_slot_label_o = s_q.last_label;

    // Read of the base offset answers zero one cycle later.
    sequence base_read_s;
        req_i.rd && req_i.addr == HPSC_OFF_BASE;
    endsequence

    base_zero_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        base_read_s |=> rsp_o.ack && rsp_o.rdata == 32'h0000_0000)
        else $error("base offset not zero");

    attn_flag_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        ##1 cfg_o.attention_button_present == $past(slotcfg[31]))
        else $error("attention flag mismatch");

    latch_flag_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        ##1 cfg_o.latch_sensor_present == $past(slotcfg[30]))
        else $error("latch flag mismatch");

    label_dir_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (slotcfg[4:0] != 5'h00) |=>
        last_slot_label_o == ($past(slotcfg[29]) ?
            11'($past(slotcfg[26:16]) + 11'($past(slotcfg[4:0])) - 11'h001) :
            11'($past(slotcfg[26:16]) - 11'($past(slotcfg[4:0])) + 11'h001)))
        else $error("label direction wrong");

    slot_label_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        ##1 cfg_o.physical_slot_label == $past(slotcfg[26:16]))
        else $error("slot label field wrong");

    first_dev_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        ##1 cfg_o.first_slot_device_number == $past(slotcfg[12:8]))
        else $error("first device field wrong");

    cap_gate_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        ##1 cap_present_o == ($past(slotcfg[4:0]) != 5'h00))
        else $error("capability presence wrong");

    mode_read_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (req_i.rd && req_i.addr == HPSC_OFF_BUSMODE) |=>
        rsp_o.rdata[31:3] == 29'h0 && rsp_o.rdata[2:0] == $past(mode_sync))
        else $error("bus mode read wrong");

    msg_num_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (req_i.rd && req_i.addr == HPSC_OFF_IRQNUM) |=>
        rsp_o.rdata == {29'h0, $past(multi_message_enable_i)})
        else $error("message number mirror wrong");

    // Read of the slot word; a late write before it must leave the value alone.
    sequence slot_read_s;
        req_i.rd && req_i.addr == HPSC_OFF_SLOTCFG;
    endsequence

    wonce_read_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (cfg_locked && slot_wr) ##2 slot_read_s |=>
        rsp_o.rdata == $past(slotcfg, 3) && rsp_o.rdata[28:27] == 2'h0)
        else $error("write-once field changed");

    rsvd_zero_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        slot_read_s |=> rsp_o.rdata[28:27] == 2'h0 && rsp_o.rdata[15:13] == 3'h0
        && rsp_o.rdata[7:5] == 3'h0)
        else $error("reserved slot bits not zero");

    label_flag_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        ##1 cfg_o.slot_label_direction == $past(slotcfg[29]))
        else $error("direction flag mismatch");

    slot_count_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        ##1 cfg_o.slot_count == $past(slotcfg[4:0]))
        else $error("slot count field wrong");
endmodule : hpsc_regs
`default_nettype wire

/* File: hpsc_sbus_model.sv */
// Behavioural model of the secondary bus side feeding the bus mode and message enable levels.
`timescale 1ns/1ps
`default_nettype none
module hpsc_sbus_model (
    // Settings asked for by the bench
    input wire logic [2:0] mode_req_i,
    input wire logic [2:0] mme_req_i,
    // Levels seen by the register bank
    output logic [2:0] bus_mode_o,
    output logic [2:0] mme_o
);
    // The bus side switches mode on its own timing, so the level moves between host clock edges.
    assign #1.3 bus_mode_o = mode_req_i;
    // The message enable comes from a register on the host clock and passes straight through.
    assign mme_o = mme_req_i;
endmodule : hpsc_sbus_model
`default_nettype wire

/* File: hpsc_regs_tb.sv */
// Self-checking testbench for the slot configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module hpsc_regs_tb;
    import hpsc_pkg::*;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    hpsc_req_t req_i = '0;
    hpsc_rsp_t rsp_o;
    logic [2:0] mode_req = 3'h0;
    logic [2:0] mme_req = 3'h0;
    logic [2:0] bus_mode;
    logic [2:0] mme;
    hpsc_cfg_t cfg_o;
    logic cap_present_o;
    logic [10:0] last_slot_label_o;
    int err_total = 0;
    int checks = 0;
    int slot_m = 0;
    int locked_m = 0;

    // Free-running host clock.
    initial begin
        forever #2 clk_i = ~clk_i;
    end

    hpsc_sbus_model hpsc_sbus_model_inst (.mode_req_i(mode_req), .mme_req_i(mme_req),
        .bus_mode_o(bus_mode), .mme_o(mme));
    hpsc_regs hpsc_regs_inst (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(req_i), .rsp_o(rsp_o),
        .bus_mode_i(bus_mode), .multi_message_enable_i(mme), .cfg_o(cfg_o),
        .cap_present_o(cap_present_o), .last_slot_label_o(last_slot_label_o));

    // Closing report, also reached when a wait runs out.
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict

    task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk_val

    // One register cycle; the strobe is a one-cycle pulse and ack follows a cycle later.
    task automatic access(input logic w, input logic [7:0] a, input logic [3:0] be,
        input logic [31:0] d, output logic [31:0] rd);
        int i;
        @(posedge clk_i);
        req_i.rd <= ~w;
        req_i.wr <= w;
        req_i.addr <= a;
        req_i.be <= be;
        req_i.wdata <= d;
        @(posedge clk_i);
        req_i.rd <= 1'b0;
        req_i.wr <= 1'b0;
        #1;
        for (i = 0; i < 4 && rsp_o.ack !== 1'b1; i++) begin
            @(posedge clk_i);
            #1;
        end
        if (rsp_o.ack !== 1'b1) begin
            err_total++;
            print_verdict();
        end
        rd = rsp_o.rdata;
    endtask : access

    // Write the slot word and let the model keep only the first write after reset.
    task automatic wr_slot(input logic [31:0] d, input logic [3:0] be);
        logic [31:0] m;
        logic [31:0] rd;
        m = 32'h0;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) m[8*b +: 8] = 8'hff;
        end
        access(1'b1, HPSC_OFF_SLOTCFG, be, d, rd);
        if (locked_m == 0) slot_m = d & m & HPSC_SLOTCFG_MASK;
        locked_m = 1;
    endtask : wr_slot

    // Decoded outputs against the model, one cycle after the write was answered.
    task automatic chk_cfg();
        logic [31:0] s;
        int lbl;
        s = slot_m;
        @(posedge clk_i);
        #1;
        lbl = s[29] ? s[26:16] + s[4:0] - 1 : s[26:16] - s[4:0] + 1;
        chk_val("cfg", {8'h0, s[31:29], s[26:16], s[12:8], s[4:0]}, {8'h0, cfg_o});
        chk_val("cap", {31'h0, s[4:0] != 5'h0}, {31'h0, cap_present_o});
        if (s[4:0] != 5'h0) chk_val("label", 32'(lbl & 'h7ff), {21'h0, last_slot_label_o});
    endtask : chk_cfg

    task automatic do_reset();
        @(posedge clk_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        slot_m = 0;
        locked_m = 0;
    endtask : do_reset

    // Main sequence.
    initial begin
        logic [31:0] d;
        logic [31:0] rd;
        logic [3:0] be;
        logic [7:0] offs [6];
        logic [63:0] bar;
        logic [63:0] ws_addr;
        offs = '{8'h00, 8'h0c, 8'h10, 8'h12, 8'h04, 8'h20};
        d = $urandom(22);
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        // Reset values, unmapped places included, all read zero.
        // base offset read first
        foreach (offs[j]) begin
            access(1'b0, offs[j], 4'hf, 32'h0, rd);
            chk_val("reset read", 32'h0, rd);
        end
        // The base offset ignores a write and still reads zero.
        access(1'b1, HPSC_OFF_BASE, 4'hf, $urandom(), rd);
        access(1'b0, HPSC_OFF_BASE, 4'hf, 32'h0, rd);
        chk_val("base", 32'h0, rd);
        bar = {$urandom(), $urandom()};
        ws_addr = bar + {32'h0000_0000, rd};
        chk_val("ws addr", bar[31:0], ws_addr[31:0]);
        // Write-once slot word with partial enables, a reset between passes, a zero count.
        for (int k = 0; k < 4; k++) begin
            do_reset();
            be = (k == 1) ? 4'h5 : ((k == 2) ? 4'ha : 4'hf);
            d = $urandom();
            if (k == 3) d[4:0] = 5'h00;
            wr_slot(d, be);
            chk_cfg();
            wr_slot(~d, 4'hf);
            access(1'b0, HPSC_OFF_SLOTCFG, 4'hf, 32'h0, rd);
            chk_val("slot", slot_m, rd);
            chk_cfg();
        end
        // Every bus mode code, given time to cross the synchroniser.
        for (int k = 0; k < 8; k++) begin
            @(posedge clk_i);
            mode_req <= 3'(k);
            repeat (5) @(posedge clk_i);
            access(1'b0, HPSC_OFF_BUSMODE, 4'hf, 32'h0, rd);
            chk_val("bus mode", 32'(k), rd);
        end
        // Message number follows every message enable value.
        for (int k = 0; k < 8; k++) begin
            @(posedge clk_i);
            mme_req <= 3'(k);
            access(1'b0, HPSC_OFF_IRQNUM, 4'hf, 32'h0, rd);
            chk_val("msg num", 32'(k), rd);
        end
        print_verdict();
    end
endmodule : hpsc_regs_tb
`default_nettype wire
